// File: rtl/pms_pkg.sv
// Purpose: shared constants and types of the mode supervisor
// Assumes: 25 MHz system clock, 8-bit register port
// Notes: offsets, fields, reset values and timing counts live here only
package pms_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 25_000_000;
  // documented register offsets
  localparam logic [7:0] WDOG_CLR_OFS = 8'h0d;
  localparam logic [7:0] PG_STATUS_OFS = 8'h20;
  localparam logic [7:0] PIN_SEL_OFS = 8'h22;
  localparam logic [7:0] RST_MON_OFS = 8'h71;
  // mode setting registers, one per mode; CTRL_OFS single, RAIL_TGT_OFS one per mode and rail
  localparam logic [7:0] MODE_CFG_OFS = 8'h30;
  localparam logic [7:0] RAIL_EN_OFS = 8'h34;
  localparam logic [7:0] CTRL_OFS = 8'h38;
  localparam logic [7:0] RAIL_TGT_OFS = 8'h40;
  // mode setting field positions
  localparam int WDOG_SEL_LSB = 0;
  localparam int PIN_SEL_BIT = 2;
  localparam int STORE_BIT = 3;
  // control register field positions
  localparam int HOST_MODE_LSB = 0;
  localparam int MON_EN_BIT = 2;
  localparam int WAKE_ACT_BIT = 3;
  localparam int CHG_HOLD_BIT = 4;
  localparam int BLEED_CORE_BIT = 5;
  localparam int BLEED_SYS_BIT = 6;
  // kick pattern and field
  localparam logic [2:0] WDOG_KICK_PAT = 3'h1;
  // status bits of reset monitor register
  localparam int KEY_LVL_BIT = 7;
  localparam int WAKE_DONE_BIT = 6;
  localparam int WDOG_IRQ_BIT = 5;
  // reset values
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [3:0] RAIL_EN_RST = 4'hf;
  localparam logic [7:0] CTRL_RST = 8'h04;
  // timing
  localparam int unsigned KEY_FILT_US = 200;
  localparam int unsigned KEY_FILT_CYC = (KEY_FILT_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SEQ_STEP_US = 100;
  localparam int unsigned SEQ_STEP_CYC = (SEQ_STEP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned LONG_BASE_S = 4;
  localparam int unsigned WDOG_BASE_S = 1;
  localparam int unsigned SEC_CYC = CLK_HZ;
  // rail count
  localparam int NRAIL = 4;
  // supervisor state
  typedef enum logic [2:0] {PMS_OFF, PMS_UP, PMS_ACTIVE, PMS_DOWN, PMS_STORE} pms_state_t;
endpackage

// File: rtl/pms_rail_if.sv
// Purpose: bundle of rail status between supervisor and window monitor
// Assumes: one clock domain
// Notes: per rail enable, window flags and transition flag
`timescale 1ns/10ps
interface pms_rail_if;
  logic [3:0] rail_on; // rails enabled in active mode
  logic [3:0] under; // synced below 90 percent flags
  logic [3:0] over; // synced above 110 percent flags
  logic [3:0] moving; // rail in voltage transition
  logic sequencing; // power-up or power-down running
  logic hold_low; // forced assert request
  logic rst_n; // resulting open-drain drive level
  modport sup (output rail_on, moving, sequencing, hold_low, input under, over, rst_n);
  modport mon (input rail_on, moving, sequencing, hold_low, output under, over, rst_n);
endinterface

// File: rtl/pms_window_mon.sv
// Purpose: per-rail window check driving system reset level
// Assumes: comparator inputs are asynchronous
// Notes: two-flop sync on every comparator line
`timescale 1ns/10ps
module pms_window_mon
  import pms_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] cmp_under,
  input wire logic [3:0] cmp_over,
  pms_rail_if.mon rif
);
  logic [3:0] und_s1_reg; // first sync stage
  logic [3:0] und_s2_reg; // second sync stage
  logic [3:0] ovr_s1_reg; // first sync stage
  logic [3:0] ovr_s2_reg; // second sync stage
  logic [3:0] bad; // per rail fault
  logic rst_n_reg; // output level
  //////////////////////////////////////////////////////////////////
  // synchronisers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      und_s1_reg <= 4'h0;
      und_s2_reg <= 4'h0;
      ovr_s1_reg <= 4'h0;
      ovr_s2_reg <= 4'h0;
    end
    else if (ce)
    begin
      und_s1_reg <= cmp_under;
      und_s2_reg <= und_s1_reg;
      ovr_s1_reg <= cmp_over;
      ovr_s2_reg <= ovr_s1_reg;
    end
  end
  // per rail fault, gated by enable and transition
  genvar gi;
  generate
    for (gi = 0; gi < NRAIL; gi++)
    begin : g_rail
      // disabled or moving rails never pull low (see RULE9) (see RULE11)
      assign bad[gi] = rif.rail_on[gi] && !rif.moving[gi] && (und_s2_reg[gi] || ovr_s2_reg[gi]); // see RULE8
    end
  endgenerate
  //////////////////////////////////////////////////////////////////
  // output level, released once cause is gone
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_n_reg <= 1'b0;
    else if (ce)
      rst_n_reg <= !(rif.hold_low || (|bad) || (rif.sequencing && (|(und_s2_reg & rif.rail_on)))); // see RULE10
  end
  assign rif.under = und_s2_reg;
  assign rif.over = ovr_s2_reg;
  assign rif.rst_n = rst_n_reg;
endmodule // pms_window_mon

// File: rtl/pms_mode_supervisor.sv
// Purpose: mode selection, storage mode, watchdog and reset supervision
// Assumes: 8-bit register port with write strobe and read data
// Notes: pins, power key and supply detect are asynchronous
// Functional notes
// (RULE1) power-up applies mode 0, pin select off
// (RULE2) pins used only when pin enable set
// (RULE3) host holds pins stable during change
// (RULE4) host keeps each pin level 5 us
// (RULE5) host changes both pins within 0.5 us
// (RULE6) pins decode hi/lo to modes 0..3
// (RULE7) wake flag readable at 0x71 for host
// (RULE8) reset low when rail outside window
// (RULE9) disabled rail never asserts reset
// (RULE10) reset low until sequencing rails reach 90%
// (RULE11) no reset while rail is moving
// (RULE12) storage bit starts storage mode immediately
// (RULE13) power down, then storage, defaults restored
// (RULE14) leave storage on key edge or supply
// (RULE15) supply wake charges; wake bit gates rails; storage resets the bit, so every supply wake powers the rails up
// (RULE16) two-bit watchdog period or disable per mode
// (RULE17) expiry: irq, reset low, mode 0 rails
// (RULE18) expiry: charge hold bit suspends charging
// (RULE19) watchdog restarts on kick or mode change
// (RULE20) per-mode enable and target per rail
// (RULE21) bleed on when disabled or stepping down
// (RULE22) monitor enable updates power-good bits
// (RULE23) key edge clears pin select enables
// (RULE24) pins ignored, host bits select mode
// (RULE25) long key press resets, rails to defaults
// (RULE26) all timing counters from system clock
`timescale 1ns/10ps
module pms_mode_supervisor
  import pms_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic mode_select_pin_lo,
  input wire logic mode_select_pin_hi,
  input wire logic power_key_n,
  input wire logic supply_valid,
  input wire logic [3:0] cmp_under,
  input wire logic [3:0] cmp_over,
  output logic system_reset_out_n_o,
  output logic system_reset_out_n_oe_n,
  output logic [3:0] rail_enable,
  output logic [1:0] active_mode,
  output logic [3:0] bleed_on,
  output logic charge_enable,
  output logic watchdog_expiry_irq
);
  // decode of a mode setting register offset
  function automatic logic hit_mode(input logic [7:0] a, input logic [7:0] base, input logic [1:0] m);
    hit_mode = (a == (base + {6'h00, m}));
  endfunction
  pms_rail_if rif();
  logic [7:0] mode_cfg_reg [4]; // per-mode watchdog, pin select, storage
  logic [3:0] rail_en_reg [4]; // per-mode rail enables
  logic [7:0] rail_tgt_reg [4][4]; // per-mode rail target codes
  logic [7:0] ctrl_reg; // host mode bits and global options
  logic [1:0] mode_reg; // active mode
  logic [1:0] mode_next; // requested mode
  logic [1:0] pin_s1_reg; // pin sync stage one
  logic [1:0] pin_s2_reg; // pin sync stage two
  logic key_s1_reg; // key sync stage one
  logic key_s2_reg; // key sync stage two
  logic sup_s1_reg; // supply sync stage one
  logic sup_s2_reg; // supply sync stage two
  logic key_filt_reg; // filtered key level
  logic [12:0] key_cnt_reg; // filter counter
  logic key_fall; // filtered falling edge
  logic [31:0] long_cnt_reg; // long-press counter
  logic long_hit; // long press reached
  logic [31:0] wd_cnt_reg; // watchdog counter
  logic wd_expire; // watchdog expired
  logic wd_irq_reg; // sticky expiry flag
  logic wake_done_reg; // woke from storage
  logic [3:0] pg_reg; // power-good bits
  logic [3:0] moving_reg; // rails in transition
  logic [3:0] step_down_reg; // rails stepping down
  logic [11:0] move_cnt_reg; // transition timer
  logic [11:0] seq_cnt_reg; // sequencing timer
  logic chg_reg; // charge enable
  logic hold_reg; // forced reset low after expiry
  logic soft_rst; // register defaults request
  logic [2:0] state_reg; // raw state bits
  pms_state_t state; // supervisor state
  pms_state_t state_next; // next supervisor state
  logic [7:0] rdata_reg; // read data
  logic [3:0] rail_out_reg; // driven rail enables
  logic [3:0] bleed_reg; // driven bleed enables
  logic [1:0] mode_out_reg; // driven mode
  logic store_req; // storage entry written
  assign state = pms_state_t'(state_reg);
  //////////////////////////////////////////////////////////////////
  // input synchronisers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      key_s1_reg <= 1'b1;
      key_s2_reg <= 1'b1;
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_reg <= {mode_select_pin_hi, mode_select_pin_lo};
      pin_s2_reg <= pin_s1_reg;
      key_s1_reg <= power_key_n;
      key_s2_reg <= key_s1_reg;
      sup_s1_reg <= supply_valid;
      sup_s2_reg <= sup_s1_reg;
    end
  end
  //////////////////////////////////////////////////////////////////
  // key deglitch filter, counted on system clock
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      key_filt_reg <= 1'b1;
      key_cnt_reg <= 13'h0000;
    end
    else if (ce)
    begin
      if (key_s2_reg == key_filt_reg)
        key_cnt_reg <= 13'h0000; // see RULE26
      else if (key_cnt_reg == 13'(KEY_FILT_CYC - 1))
      begin
        key_filt_reg <= key_s2_reg;
        key_cnt_reg <= 13'h0000;
      end
      else
        key_cnt_reg <= key_cnt_reg + 13'h0001;
    end
  end
  assign key_fall = key_filt_reg && (key_s2_reg == 1'b0) && (key_cnt_reg == 13'(KEY_FILT_CYC - 1));
  // long press: fixed 4 s period (LONG_BASE_S), counted while the filtered key stays low
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      long_cnt_reg <= 32'h0000_0000;
    else if (ce)
    begin
      if (key_filt_reg || long_hit)
        long_cnt_reg <= 32'h0000_0000;
      else
        long_cnt_reg <= long_cnt_reg + 32'h0000_0001;
    end
  end
  assign long_hit = (long_cnt_reg == 32'(LONG_BASE_S * SEC_CYC - 1)); // see RULE25
  //////////////////////////////////////////////////////////////////
  // watchdog period: sel 0 off, else sel seconds; restart on kick or mode change
  logic kick;
  logic [1:0] wd_sel;
  assign wd_sel = mode_cfg_reg[mode_reg][WDOG_SEL_LSB +: 2];
  assign kick = reg_wr && (reg_addr == WDOG_CLR_OFS) && (reg_wdata[2:0] == WDOG_KICK_PAT);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wd_cnt_reg <= 32'h0000_0000;
    else if (ce)
    begin
      if (wd_sel == 2'h0 || state != PMS_ACTIVE)
        wd_cnt_reg <= 32'h0000_0000; // see RULE16
      else if (kick || (mode_next != mode_reg) || wd_expire)
        wd_cnt_reg <= 32'h0000_0000; // see RULE19
      else
        wd_cnt_reg <= wd_cnt_reg + 32'h0000_0001; // see RULE26
    end
  end
  assign wd_expire = (wd_sel != 2'h0) && (wd_cnt_reg == 32'({30'h0, wd_sel} * WDOG_BASE_S * SEC_CYC - 1));
  //////////////////////////////////////////////////////////////////
  // mode request: pins when enabled, else host bits
  always_comb
  begin
    mode_next = mode_reg;
    if (state == PMS_ACTIVE && moving_reg == 4'h0) // see RULE3
    begin
      if (mode_cfg_reg[mode_reg][PIN_SEL_BIT])
        mode_next = {pin_s2_reg[1], pin_s2_reg[0]}; // see RULE2 (see RULE6)
      else
        mode_next = ctrl_reg[HOST_MODE_LSB +: 2]; // see RULE24
    end
  end
  assign store_req = reg_wr && ((reg_addr & 8'hfc) == MODE_CFG_OFS) && reg_wdata[STORE_BIT];
  assign soft_rst = (state == PMS_STORE) || long_hit;
  //////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int m = 0; m < 4; m++)
      begin
        mode_cfg_reg[m] <= MODE_CFG_RST; // see RULE1
        rail_en_reg[m] <= RAIL_EN_RST;
        for (int r = 0; r < 4; r++)
          rail_tgt_reg[m][r] <= 8'h00;
      end
      ctrl_reg <= CTRL_RST;
    end
    else if (ce)
    begin
      if (soft_rst)
      begin
        for (int m = 0; m < 4; m++)
        begin
          mode_cfg_reg[m] <= MODE_CFG_RST; // see RULE13
          rail_en_reg[m] <= RAIL_EN_RST;
          for (int r = 0; r < 4; r++)
            rail_tgt_reg[m][r] <= 8'h00;
        end
        ctrl_reg <= CTRL_RST;
      end
      else
      begin
        for (int m = 0; m < 4; m++)
        begin
          if (reg_wr && hit_mode(reg_addr, MODE_CFG_OFS, 2'(m)))
            mode_cfg_reg[m] <= reg_wdata;
          if (reg_wr && hit_mode(reg_addr, RAIL_EN_OFS, 2'(m)))
            rail_en_reg[m] <= reg_wdata[3:0]; // see RULE20
          for (int r = 0; r < 4; r++)
            if (reg_wr && (reg_addr == (RAIL_TGT_OFS + 8'(m * 4 + r))))
              rail_tgt_reg[m][r] <= reg_wdata;
          if (reg_wr && reg_addr == PIN_SEL_OFS)
            mode_cfg_reg[m][PIN_SEL_BIT] <= reg_wdata[m];
          if (key_fall)
            mode_cfg_reg[m][PIN_SEL_BIT] <= 1'b0; // see RULE23
        end
        if (reg_wr && reg_addr == CTRL_OFS)
          ctrl_reg <= reg_wdata;
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // supervisor state machine
  always_comb
  begin
    state_next = state;
    case (state)
      PMS_OFF: if (key_fall || sup_s2_reg) state_next = PMS_UP;
      PMS_UP: if (seq_cnt_reg == 12'(SEQ_STEP_CYC - 1)) state_next = PMS_ACTIVE;
      PMS_ACTIVE: if (store_req) state_next = PMS_DOWN; // see RULE12
      PMS_DOWN: if (seq_cnt_reg == 12'(SEQ_STEP_CYC - 1)) state_next = PMS_STORE; // see RULE13
      PMS_STORE:
      begin
        if (key_fall)
          state_next = PMS_UP; // see RULE14
        else if (sup_s2_reg)
          state_next = ctrl_reg[WAKE_ACT_BIT] ? PMS_OFF : PMS_UP; // see RULE15
      end
      default: state_next = PMS_OFF;
    endcase
    if (store_req && state != PMS_STORE && state != PMS_OFF)
      state_next = PMS_DOWN; // see RULE12
    if (long_hit)
      state_next = PMS_UP; // see RULE25
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= 3'(PMS_OFF);
      seq_cnt_reg <= 12'h000;
    end
    else if (ce)
    begin
      state_reg <= 3'(state_next);
      seq_cnt_reg <= (state_next != state) ? 12'h000 : seq_cnt_reg + 12'h001;
    end
  end
  //////////////////////////////////////////////////////////////////
  // active mode, transition tracking and watchdog actions
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_reg <= 2'h0; // see RULE1
      moving_reg <= 4'h0;
      step_down_reg <= 4'h0;
      move_cnt_reg <= 12'h000;
      hold_reg <= 1'b0;
    end
    else if (ce)
    begin
      hold_reg <= wd_expire; // see RULE17
      if (soft_rst || wd_expire)
        mode_reg <= 2'h0; // see RULE17
      else if (mode_next != mode_reg)
      begin
        mode_reg <= mode_next;
        move_cnt_reg <= 12'h000;
        for (int r = 0; r < 4; r++)
        begin
          moving_reg[r] <= rail_tgt_reg[mode_next][r] != rail_tgt_reg[mode_reg][r]; // see RULE11
          step_down_reg[r] <= rail_tgt_reg[mode_next][r] < rail_tgt_reg[mode_reg][r];
        end
      end
      else if (moving_reg != 4'h0)
      begin
        move_cnt_reg <= move_cnt_reg + 12'h001;
        if (move_cnt_reg == 12'(SEQ_STEP_CYC - 1))
        begin
          moving_reg <= 4'h0;
          step_down_reg <= 4'h0;
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // status flags: set wins over clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wd_irq_reg <= 1'b0;
      wake_done_reg <= 1'b0;
      pg_reg <= 4'h0;
      chg_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wd_expire)
        wd_irq_reg <= 1'b1; // see RULE17
      else if (reg_rd && reg_addr == RST_MON_OFS)
        wd_irq_reg <= 1'b0;
      if (state == PMS_STORE && state_next != PMS_STORE)
        wake_done_reg <= 1'b1; // see RULE7
      else if (reg_rd && reg_addr == RST_MON_OFS)
        wake_done_reg <= 1'b0;
      if (ctrl_reg[MON_EN_BIT])
        pg_reg <= rail_out_reg & ~rif.under; // see RULE22
      if (wd_expire && ctrl_reg[CHG_HOLD_BIT])
        chg_reg <= 1'b0; // see RULE18
      else if (state == PMS_STORE && sup_s2_reg)
        chg_reg <= 1'b1; // see RULE15
      else if (state != PMS_STORE && sup_s2_reg && !hold_reg)
        chg_reg <= chg_reg | !ctrl_reg[CHG_HOLD_BIT] | !wd_irq_reg;
      else if (!sup_s2_reg)
        chg_reg <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////
  // outputs and read data
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rail_out_reg <= 4'h0;
      bleed_reg <= 4'hf;
      mode_out_reg <= 2'h0;
      rdata_reg <= 8'h00;
    end
    else if (ce)
    begin
      rail_out_reg <= (state == PMS_ACTIVE || state == PMS_UP) ? rail_en_reg[mode_reg] : 4'h0;
      // bleed when off or stepping down, unless disabled for bucks (see RULE21)
      bleed_reg <= (~rail_out_reg | step_down_reg) & ~{ctrl_reg[BLEED_SYS_BIT], ctrl_reg[BLEED_CORE_BIT], 2'b00};
      mode_out_reg <= mode_reg;
      rdata_reg <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          PG_STATUS_OFS: rdata_reg <= {4'h0, pg_reg};
          RST_MON_OFS: rdata_reg <= {key_filt_reg, wake_done_reg, wd_irq_reg, 5'h00};
          PIN_SEL_OFS: rdata_reg <= {4'h0, mode_cfg_reg[3][PIN_SEL_BIT], mode_cfg_reg[2][PIN_SEL_BIT],
                                     mode_cfg_reg[1][PIN_SEL_BIT], mode_cfg_reg[0][PIN_SEL_BIT]};
          CTRL_OFS: rdata_reg <= ctrl_reg;
          default:
          begin
            for (int m = 0; m < 4; m++)
            begin
              if (hit_mode(reg_addr, MODE_CFG_OFS, 2'(m)))
                rdata_reg <= mode_cfg_reg[m];
              if (hit_mode(reg_addr, RAIL_EN_OFS, 2'(m)))
                rdata_reg <= {4'h0, rail_en_reg[m]};
            end
          end
        endcase
      end
    end
  end
  assign rif.rail_on = rail_out_reg;
  assign rif.moving = moving_reg;
  assign rif.sequencing = (state == PMS_UP) || (state == PMS_DOWN);
  assign rif.hold_low = hold_reg || (state != PMS_ACTIVE);
  pms_window_mon u_mon (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .cmp_under(cmp_under),
    .cmp_over(cmp_over),
    .rif(rif)
  );
  assign system_reset_out_n_o = 1'b0;
  assign system_reset_out_n_oe_n = rif.rst_n; // low enable drives low
  assign reg_rdata = rdata_reg;
  assign rail_enable = rail_out_reg;
  assign active_mode = mode_out_reg;
  assign bleed_on = bleed_reg;
  assign charge_enable = chg_reg;
  assign watchdog_expiry_irq = wd_irq_reg;
endmodule // pms_mode_supervisor

// File: test/pms_mode_monitor.sv
// Purpose: port-level checks of the mode supervisor
// Assumes: one clock, asynchronous active-low reset
// Notes: quiet_cnt marks rails, mode and registers as settled
`timescale 1ns/10ps
module pms_mode_monitor
  import pms_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic power_key_n,
  input wire logic [3:0] cmp_under,
  input wire logic [3:0] cmp_over,
  input wire logic system_reset_out_n_o,
  input wire logic system_reset_out_n_oe_n,
  input wire logic [3:0] rail_enable,
  input wire logic [1:0] active_mode,
  input wire logic [3:0] bleed_on,
  input wire logic watchdog_expiry_irq
);
  logic [11:0] quiet_cnt; // settled cycles, saturating
  logic [3:0] bad_rail; // window flags of rails that are on
  assign bad_rail = (cmp_under | cmp_over) & rail_enable;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // restart on register writes and on rail or mode movement
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      quiet_cnt <= 12'h000;
    else if (reg_wr || $changed(rail_enable) || $changed(active_mode))
      quiet_cnt <= 12'h000;
    else if (quiet_cnt != 12'hfff)
      quiet_cnt <= quiet_cnt + 12'h001;
  ////////////////////////////////////////////////////////////
  a_drive_data_low: assert property (system_reset_out_n_o == 1'b0)
    else $error("reset pin data not low");
  a_window_asserts: assert property ((quiet_cnt > 12'ha8c && bad_rail != 4'h0) [*4] |-> !system_reset_out_n_oe_n)
    else $error("rail out of window left reset released");
  a_clean_stays_high: assert property ((quiet_cnt > 12'ha8c && power_key_n && system_reset_out_n_oe_n
    && bad_rail == 4'h0) [*4] ##1 !watchdog_expiry_irq |-> system_reset_out_n_oe_n)
    else $error("reset asserted with no enabled rail at fault");
  a_release_clean: assert property ($rose(system_reset_out_n_oe_n) |-> ($past(cmp_under, 3) & rail_enable) == 4'h0)
    else $error("reset released while enabled rail under");
  a_status_low_zero: assert property (ce && reg_rd && reg_addr == RST_MON_OFS |=> reg_rdata[4:0] == 5'h00)
    else $error("status register low bits not zero");
  a_bleed_aon: assert property ((!rail_enable[0]) [*3] |-> bleed_on[0])
    else $error("aon rail off without discharge");
  a_bleed_sys_ldo: assert property ((!rail_enable[1]) [*3] |-> bleed_on[1])
    else $error("system linear rail off without discharge");
  a_expiry_resets: assert property ($rose(watchdog_expiry_irq) |-> ##[0:2] !system_reset_out_n_oe_n)
    else $error("watchdog expiry without reset");
  c_released: cover property ($rose(system_reset_out_n_oe_n));
  c_mode_three: cover property (active_mode == 2'h3);
  c_rails_off: cover property ($fell(|rail_enable));
endmodule // pms_mode_monitor
bind pms_mode_supervisor pms_mode_monitor mon (.*);

// File: test/pms_host_model.sv
// Purpose: host-side driver of the two mode select pins
// Assumes: 40 ns clock, levels held at least 5 us
// Notes: both pins move on one edge; new level only when asked
`timescale 1ns/10ps
module pms_host_model #(
  parameter int HOLD_CYC = 125 // 5 us in 40 ns cycles
) (
  input wire logic clk,
  input wire logic [1:0] want_mode,
  output logic mode_select_pin_lo,
  output logic mode_select_pin_hi
);
  int held = 0; // cycles since the pins last moved
  initial {mode_select_pin_hi, mode_select_pin_lo} = 2'h3;
  // move both pins together once the old level has stood long enough
  always @(posedge clk)
    if (held >= HOLD_CYC && want_mode != {mode_select_pin_hi, mode_select_pin_lo})
    begin
      {mode_select_pin_hi, mode_select_pin_lo} <= #1 want_mode;
      held <= 0;
    end
    else
      held <= held + 1;
endmodule // pms_host_model

// File: test/tb_top.sv
// Purpose: self-checking bench of the mode supervisor
// Assumes: 25 MHz clock, inputs moved 1 ns after the rising edge
// Notes: key and clock enable stay idle; supply and comparators driven
`timescale 1ns/10ps
module tb_top
  import pms_pkg::*;
;
  logic clk = 0, nrst = 0, ce = 1, reg_wr = 0, reg_rd = 0, power_key_n = 1, supply_valid = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  logic [3:0] cmp_under = 4'h0, cmp_over = 4'h0, rail_enable, bleed_on;
  logic [1:0] active_mode, want_mode = 2'h3;
  logic mode_select_pin_lo, mode_select_pin_hi, system_reset_out_n_o, system_reset_out_n_oe_n;
  logic charge_enable, watchdog_expiry_irq, rst_line;
  int err_total = 0, n_compared = 0, cyc = 0;
  assign rst_line = system_reset_out_n_oe_n ? 1'b1 : system_reset_out_n_o; // pull-up when released
  pms_mode_supervisor dut (.*);
  pms_host_model host (.clk(clk), .want_mode(want_mode), .mode_select_pin_lo(mode_select_pin_lo),
    .mode_select_pin_hi(mode_select_pin_hi));
  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total = err_total + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one write, strobe low for a cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    step(1);
    reg_wr = 0;
    step(1);
  endtask
  // one read, data taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1;
    step(1);
    reg_rd = 0;
    d = reg_rdata;
    step(1);
  endtask
  task automatic wait_line(input logic lvl);
    for (int i = 0; i < 8000 && rst_line !== lvl; i++)
      step(1);
  endtask
  task automatic wait_mode(input logic [1:0] m);
    for (int i = 0; i < 8000 && active_mode !== m; i++)
      step(1);
  endtask
  ////////////////////////////////////////////////////////////
  // defaults after reset, unmapped read
  task automatic t_regs();
    rd(RST_MON_OFS, rd_val);
    chk(rd_val, 8'h80);
    rd(MODE_CFG_OFS, rd_val);
    chk(rd_val, 8'h00);
    rd(PIN_SEL_OFS, rd_val);
    chk(rd_val, 8'h00);
    rd(8'h01, rd_val);
    chk(rd_val, 8'h00);
  endtask
  // supply start, rail low through power-up, pins at 3 ignored
  task automatic t_powerup();
    cmp_under = 4'h1;
    supply_valid = 1;
    step(3000);
    chk(8'(rst_line), 8'h00);
    rd(PG_STATUS_OFS, rd_val);
    chk(rd_val, 8'h0e);
    cmp_under = 4'h0;
    wait_line(1);
    chk(8'(rst_line), 8'h01);
    chk(8'(active_mode), 8'h00);
    chk(8'(rail_enable), 8'h0f);
  endtask
  // host bits pick mode 2, no reset during the move
  task automatic t_host();
    wr(RAIL_TGT_OFS + 8'h08, 8'h10); // rail 0 moves
    wr(CTRL_OFS, 8'h06);
    cmp_under = 4'h1;
    step(1000);
    chk(8'(rst_line), 8'h01);
    cmp_under = 4'h0;
    wait_mode(2'h2);
    chk(8'(active_mode), 8'h02);
    step(2800);
  endtask
  // pins take over, every decode visited
  task automatic t_pins();
    wr(PIN_SEL_OFS, 8'h0f);
    for (int m = 0; m < 4; m++)
      wr(MODE_CFG_OFS + 8'(m), 8'h04);
    for (int i = 3; i >= 0; i--)
    begin
      want_mode = 2'(i);
      wait_mode(2'(i));
      chk(8'(active_mode), 8'(i));
      step(2800); // pins held until the change is over
    end
  endtask
  // window faults on enabled and disabled rails
  task automatic t_window();
    cmp_over = 4'h4;
    step(5);
    chk(8'(rst_line), 8'h00);
    cmp_over = 4'h0;
    step(5);
    chk(8'(rst_line), 8'h01);
    wr(RAIL_EN_OFS, 8'h0e);
    step(3000);
    cmp_under = 4'h1;
    step(6);
    chk(8'(rst_line), 8'h01);
    chk(8'(rail_enable), 8'h0e);
    chk(8'(bleed_on[0]), 8'h01);
    cmp_under = 4'h0;
  endtask
  // storage entry, defaults, wake by supply attach
  task automatic t_storage();
    wr(MODE_CFG_OFS, 8'h0c);
    supply_valid = 0;
    chk(8'(rst_line), 8'h00);
    chk(8'(rail_enable), 8'h00);
    step(2600);
    rd(CTRL_OFS, rd_val);
    chk(rd_val, 8'h04);
    rd(PIN_SEL_OFS, rd_val);
    chk(rd_val, 8'h00);
    supply_valid = 1;
    wait_line(1);
    chk(8'(rail_enable), 8'h0f);
    chk(8'(charge_enable), 8'h01);
    rd(RST_MON_OFS, rd_val);
    chk(rd_val, 8'hc0);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    step(6);
    chk(8'(rst_line), 8'h00);
    chk({rail_enable, 2'h0, active_mode}, 8'h00);
    chk({4'h0, bleed_on}, 8'h0f);
    nrst = 1;
    step(2);
    t_regs();
    t_powerup();
    t_host();
    t_pins();
    t_window();
    t_storage();
    end_of_test();
  end
endmodule // tb_top
